/* inc/crgen_pkg.sv */
// Package with constants and types of the clock, ready and reset generator
package crgen_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS     = 50;
  // System clock cycles that ready stays asserted, at least
  localparam int unsigned READY_HOLD_CYCLES = 2;
  localparam logic [1:0]  READY_HOLD        = 2'(READY_HOLD_CYCLES);
  // Peripheral clock falling edges from detection to freeze
  localparam logic [1:0]  FREEZE_PCLK_FALLS = 2'h2;
  // Falling edges of the new source before the system clock restarts
  localparam logic [1:0]  RESTART_SRC_FALLS = 2'h2;

  // ---------------------------------------------------------------
  // Synchroniser lanes
  // ---------------------------------------------------------------
  localparam int unsigned SYNC_LANES  = 10;
  localparam int unsigned LN_SEL      = 0;
  localparam int unsigned LN_XTAL     = 1;
  localparam int unsigned LN_EFI      = 2;
  localparam int unsigned LN_ASYNC_READY_N     = 3;
  localparam int unsigned LN_ASYNC_READY_ENABLE_N   = 4;
  localparam int unsigned LN_SYNC_READY_N     = 5;
  localparam int unsigned LN_SYNC_READY_ENABLE_N   = 6;
  localparam int unsigned LN_STLO     = 7;
  localparam int unsigned LN_STHI     = 8;
  localparam int unsigned LN_RESREQ   = 9;
  // Idle level of every lane after reset: active-low pins idle high
  localparam logic [9:0]  SYNC_RESET  = 10'h3F8;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic        SEL_RESET   = 1'b0;
  localparam logic        PCLK_RESET  = 1'b1;
  localparam logic        RESET_OUT_RESET = 1'b1;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CRG_RUN,
    CRG_ARMED,
    CRG_FROZEN
  } crg_switch_e;

endpackage

/* src/crgen_top.sv */
// Clock, ready and reset generator: clock select, PCLK, READY, RESET
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Select low: system clock follows crystal
// - Select high: system clock follows external input
// - Select may switch while running, no reset
// - Peripheral clock is system clock halved
// - Peripheral clock aligned after first bus cycle
// - Async enable qualifies async ready, synchronised
// - Async ready synchronised, ends bus cycle
// - Ready output open drain, pulls low only
// - Ready from readies, enables, status, reset
// - Status prepares cycle, aligns clock, controls ready
// - Active-high reset output from reset request
// - Ready held asserted while reset asserted
// - Reset request asynchronous, synchronised before use
// - Reset request sampled on system clock fall
// - Ready on enabled low input, two cycles
// - Status low two cycles forces PCLK high
// - Select change freezes clock at second PCLK fall
module crgen_top
  import crgen_pkg::*;
(
  // Clock and reset
  input  wire logic CLK,
  input  wire logic RESET_N,
  input  wire logic CE,
  // Clock sources and select
  input  wire logic CLOCK_SELECT,
  input  wire logic CRYSTAL_PIN_IN,
  output logic      CRYSTAL_PIN_OUT,
  input  wire logic EXTERNAL_FREQUENCY_INPUT,
  // Generated clocks
  output logic      SYS_CLK_OUT,
  output logic      PCLK_OUT,
  // Ready sources
  input  wire logic ASYNC_READY_N,
  input  wire logic ASYNC_READY_ENABLE_N,
  input  wire logic SYNC_READY_N,
  input  wire logic SYNC_READY_ENABLE_N,
  // Bus status
  input  wire logic BUS_STATUS_LOW_N,
  input  wire logic BUS_STATUS_HIGH_N,
  // Ready output, open drain
  output logic      READY_N_OUT,
  output logic      READY_N_OE,
  // System reset
  input  wire logic RESET_REQUEST_N,
  output logic      RESET_OUT
);
  import crgen_pkg::*;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [SYNC_LANES-1:0] pin_raw;
  logic [SYNC_LANES-1:0] sync_a;
  logic [SYNC_LANES-1:0] sync_b;
  logic [SYNC_LANES-1:0] next_sync_a;
  logic [SYNC_LANES-1:0] next_sync_b;

  assign pin_raw = {RESET_REQUEST_N, BUS_STATUS_HIGH_N, BUS_STATUS_LOW_N,
                    SYNC_READY_ENABLE_N, SYNC_READY_N,
                    ASYNC_READY_ENABLE_N, ASYNC_READY_N,
                    EXTERNAL_FREQUENCY_INPUT, CRYSTAL_PIN_IN, CLOCK_SELECT};

  // Stage a is read only by stage b
  for (genvar g = 0; g < SYNC_LANES; g++) begin : g_sync
    always_comb begin
      next_sync_a[g] = CE ? pin_raw[g] : sync_a[g];
      next_sync_b[g] = CE ? sync_a[g] : sync_b[g];
    end
    always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        sync_a[g] <= SYNC_RESET[g];
        sync_b[g] <= SYNC_RESET[g];
      end else begin
        sync_a[g] <= next_sync_a[g];
        sync_b[g] <= next_sync_b[g];
      end
    end
  end

  logic sel_s;
  logic xtal_s;
  logic efi_s;
  assign sel_s  = sync_b[LN_SEL];
  assign xtal_s = sync_b[LN_XTAL];
  assign efi_s  = sync_b[LN_EFI];

  // ---------------------------------------------------------------
  // Source selection and switchover
  // ---------------------------------------------------------------
  crg_switch_e state;
  crg_switch_e next_state;
  logic        active_sel;
  logic        next_active_sel;
  logic        target_sel;
  logic        next_target_sel;
  logic [1:0]  edge_cnt;
  logic [1:0]  next_edge_cnt;
  logic        sys_clk;
  logic        next_sys_clk;
  logic        xtal_prev;
  logic        efi_prev;
  logic        pclk;
  logic        pclk_prev;
  logic        tgt_now;
  logic        tgt_prev;
  logic        pclk_fell;

  assign tgt_now   = target_sel ? efi_s : xtal_s;
  assign tgt_prev  = target_sel ? efi_prev : xtal_prev;
  assign pclk_fell = pclk_prev & ~pclk;

  always_comb begin
    next_state      = state;
    next_active_sel = active_sel;
    next_target_sel = target_sel;
    next_edge_cnt   = edge_cnt;
    next_sys_clk    = active_sel ? efi_s : xtal_s;
    unique case (state)
      CRG_RUN: begin
        // Select only looked at while both clocks are high
        if (sys_clk && pclk && sel_s != active_sel) begin
          next_state      = CRG_ARMED;
          next_target_sel = sel_s;
          next_edge_cnt   = 2'h0;
        end
      end
      CRG_ARMED: begin
        if (pclk_fell) begin
          next_edge_cnt = edge_cnt + 2'h1;
          if (edge_cnt + 2'h1 == FREEZE_PCLK_FALLS) begin
            next_state    = CRG_FROZEN;
            next_edge_cnt = 2'h0;
            next_sys_clk  = 1'b0;
          end
        end
      end
      CRG_FROZEN: begin
        next_sys_clk = 1'b0;
        if (tgt_prev && !tgt_now && edge_cnt != RESTART_SRC_FALLS) begin
          next_edge_cnt = edge_cnt + 2'h1;
        end
        // Restart on the new source's rising edge, never a runt pulse
        if (edge_cnt == RESTART_SRC_FALLS && !tgt_prev && tgt_now) begin
          next_state      = CRG_RUN;
          next_active_sel = target_sel;
          next_sys_clk    = 1'b1;
        end
      end
    endcase
    if (!CE) begin
      next_state      = state;
      next_active_sel = active_sel;
      next_target_sel = target_sel;
      next_edge_cnt   = edge_cnt;
      next_sys_clk    = sys_clk;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state      <= CRG_RUN;
      active_sel <= SEL_RESET;
      target_sel <= SEL_RESET;
      edge_cnt   <= 2'h0;
      sys_clk    <= 1'b0;
      xtal_prev  <= 1'b0;
      efi_prev   <= 1'b0;
    end else begin
      state      <= next_state;
      active_sel <= next_active_sel;
      target_sel <= next_target_sel;
      edge_cnt   <= next_edge_cnt;
      sys_clk    <= next_sys_clk;
      xtal_prev  <= CE ? xtal_s : xtal_prev;
      efi_prev   <= CE ? efi_s : efi_prev;
    end
  end

  logic sys_rise;
  logic sys_fall;
  assign sys_rise = CE & ~sys_clk & next_sys_clk;
  assign sys_fall = CE & sys_clk & ~next_sys_clk;

  // ---------------------------------------------------------------
  // Peripheral clock with status alignment
  // ---------------------------------------------------------------
  logic       st_low;
  logic [1:0] st_hist;
  logic [1:0] next_st_hist;
  logic       next_pclk;
  logic       next_pclk_prev;

  assign st_low = ~sync_b[LN_STLO] | ~sync_b[LN_STHI];

  always_comb begin
    next_st_hist   = st_hist;
    next_pclk      = pclk;
    next_pclk_prev = CE ? pclk : pclk_prev;
    if (sys_rise) begin
      next_st_hist = {st_hist[0], st_low};
      // Stretching the high phase is what pulls the phase in line
      if (st_hist == 2'h3) begin
        next_pclk = 1'b1;
      end else begin
        next_pclk = ~pclk;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_hist   <= 2'h0;
      pclk      <= PCLK_RESET;
      pclk_prev <= PCLK_RESET;
    end else begin
      st_hist   <= next_st_hist;
      pclk      <= next_pclk;
      pclk_prev <= next_pclk_prev;
    end
  end

  // ---------------------------------------------------------------
  // Reset and ready generation
  // ---------------------------------------------------------------
  logic       reset_out;
  logic       next_reset_out;
  logic [1:0] ready_cnt;
  logic [1:0] next_ready_cnt;
  logic       ready_req;
  logic       ready_act;

  // Either low ready paired with its low enable; none enabled waits
  assign ready_req = (~sync_b[LN_SYNC_READY_N] & ~sync_b[LN_SYNC_READY_ENABLE_N]) |
                     (~sync_b[LN_ASYNC_READY_N] & ~sync_b[LN_ASYNC_READY_ENABLE_N]);

  always_comb begin
    next_reset_out = reset_out;
    next_ready_cnt = ready_cnt;
    if (sys_fall) begin
      next_reset_out = ~sync_b[LN_RESREQ];
      if (ready_req && !st_low) begin
        next_ready_cnt = READY_HOLD;
      end else if (ready_cnt != 2'h0) begin
        next_ready_cnt = ready_cnt - 2'h1;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      reset_out <= RESET_OUT_RESET;
      ready_cnt <= 2'h0;
    end else begin
      reset_out <= next_reset_out;
      ready_cnt <= next_ready_cnt;
    end
  end

  assign ready_act = (ready_cnt != 2'h0) | reset_out;

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign SYS_CLK_OUT     = sys_clk;
  assign PCLK_OUT        = pclk;
  // Taken after the second stage: no logic may read the first stage
  assign CRYSTAL_PIN_OUT = ~xtal_s;
  assign RESET_OUT       = reset_out;
  assign READY_N_OUT     = 1'b0;
  assign READY_N_OE      = ready_act;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  AST_FROZEN_LOW: assert property (state == CRG_FROZEN |-> !sys_clk)
    else $error("System clock not low while frozen");
  AST_SRC_XTAL: assert property (CE && state == CRG_RUN && !active_sel
      |=> sys_clk == $past(xtal_s) || state != CRG_RUN)
    else $error("System clock does not follow crystal");
  AST_SRC_EFI: assert property (CE && state == CRG_RUN && active_sel
      |=> sys_clk == $past(efi_s) || state != CRG_RUN)
    else $error("System clock does not follow external input");
  AST_SWITCH_ARM: assert property (CE && state == CRG_RUN && sys_clk && pclk
      && sel_s != active_sel |=> state == CRG_ARMED)
    else $error("Select change not detected");
  AST_PCLK_TOGGLE: assert property (sys_rise && st_hist != 2'h3
      |=> pclk != $past(pclk))
    else $error("Peripheral clock did not toggle");
  AST_PCLK_FORCE: assert property (sys_rise && st_hist == 2'h3
      |=> pclk)
    else $error("Peripheral clock not forced high");
  AST_RESET_FOLLOW: assert property (sys_fall
      |=> reset_out == !$past(sync_b[LN_RESREQ]))
    else $error("Reset output does not follow request");
  AST_READY_IN_RESET: assert property (reset_out |-> READY_N_OE)
    else $error("Ready released during reset");
  AST_READY_SET: assert property (sys_fall && ready_req && !st_low
      |=> ready_cnt == READY_HOLD && READY_N_OE)
    else $error("Ready not asserted on enabled request");
  AST_READY_IDLE: assert property (ready_cnt == 2'h0 && !reset_out
      |-> !READY_N_OE)
    else $error("Ready driven without cause");

  COV_SWITCH: cover property (state == CRG_FROZEN ##1 state == CRG_RUN);
  COV_READY: cover property (sys_fall && ready_req ##1 READY_N_OE);
  COV_FORCE: cover property (sys_rise && st_hist == 2'h3);
  COV_RESET: cover property (reset_out ##1 !reset_out);

endmodule

`default_nettype wire

/* verification/crgen_partner.sv */
// Far-side model: oscillator waves and the pulled-up ready wire
`timescale 1ns/1ps
`default_nettype none

module crgen_partner (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Oscillator waves
  output logic      crystal_wave,
  output logic      efi_wave,
  // Ready wire
  input  wire logic ready_n_out,
  input  wire logic ready_n_oe,
  output logic      ready_wire_n
);
  // -------------------------------------------------------------
  // Oscillators
  // -------------------------------------------------------------
  // Crystal period 8 CLK, external period 12 CLK, both well below
  // the sampling rate so no edge is lost in the synchronisers
  logic [3:0] xtal_cnt;
  logic [3:0] efi_cnt;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      xtal_cnt     <= 4'h0;
      efi_cnt      <= 4'h0;
      crystal_wave <= 1'b0;
      efi_wave     <= 1'b0;
    end else begin
      xtal_cnt <= (xtal_cnt == 4'h3) ? 4'h0 : xtal_cnt + 4'h1;
      efi_cnt  <= (efi_cnt == 4'h5) ? 4'h0 : efi_cnt + 4'h1;
      if (xtal_cnt == 4'h3) crystal_wave <= !crystal_wave;
      if (efi_cnt == 4'h5) efi_wave <= !efi_wave;
    end
  end

  // -------------------------------------------------------------
  // Ready wire
  // -------------------------------------------------------------
  // Pull-up holds the wire high whenever the pin is released
  assign ready_wire_n = ready_n_oe ? ready_n_out : 1'b1;
endmodule

`default_nettype wire

/* verification/tb_clock_ready_reset_generator.sv */
// Testbench of the clock, ready and reset generator
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
  n_errors++; $display("[ERR] %0t got %h exp %h", $time, got, exp); end end

module tb_clock_ready_reset_generator;
  // -------------------------------------------------------------
  // Signals
  // -------------------------------------------------------------
  logic clk     = 1'b0;
  logic reset_n = 1'b0;
  logic ce      = 1'b1;
  logic sel     = 1'b0;
  logic rrq_n   = 1'b1;
  logic async_ready_n_n  = 1'b1;
  logic arden_n = 1'b1;
  logic sync_ready_n_n  = 1'b1;
  logic srden_n = 1'b1;
  logic stlo_n  = 1'b1;
  logic sthi_n  = 1'b1;
  logic xtal, external_frequency_input, xout, sys, pclk, rdy_out, rdy_oe, rdy_w, rst_out;
  int   n_errors    = 0;
  int   checks_done = 0;

  crgen_top dut (
    .CLK(clk), .RESET_N(reset_n), .CE(ce), .CLOCK_SELECT(sel),
    .CRYSTAL_PIN_IN(xtal), .CRYSTAL_PIN_OUT(xout),
    .EXTERNAL_FREQUENCY_INPUT(external_frequency_input), .SYS_CLK_OUT(sys), .PCLK_OUT(pclk),
    .ASYNC_READY_N(async_ready_n_n), .ASYNC_READY_ENABLE_N(arden_n),
    .SYNC_READY_N(sync_ready_n_n), .SYNC_READY_ENABLE_N(srden_n),
    .BUS_STATUS_LOW_N(stlo_n), .BUS_STATUS_HIGH_N(sthi_n),
    .READY_N_OUT(rdy_out), .READY_N_OE(rdy_oe),
    .RESET_REQUEST_N(rrq_n), .RESET_OUT(rst_out));

  crgen_partner partner (
    .clk(clk), .reset_n(reset_n), .crystal_wave(xtal), .efi_wave(external_frequency_input),
    .ready_n_out(rdy_out), .ready_n_oe(rdy_oe), .ready_wire_n(rdy_w));

  initial begin
    forever #25 clk = !clk;
  end

  // -------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------
  task automatic finish_test();
    if (n_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Bounded wait on RESET_OUT (0) or ready wire (1); returns cycles
  task automatic wait_sig(input int which, input logic v, output int n);
    n = 0;
    while (((which == 0) ? rst_out : rdy_w) !== v) begin
      @(negedge clk);
      n++;
      if (n > 300) begin
        n_errors++;
        finish_test();
      end
    end
  endtask

  task automatic count_edges(input int n, output int s, output int p);
    logic ls, lp;
    s  = 0;
    p  = 0;
    ls = sys;
    lp = pclk;
    repeat (n) begin
      @(negedge clk);
      if (sys && !ls) s++;
      if (pclk && !lp) p++;
      ls = sys;
      lp = pclk;
    end
  endtask

  // Drive one ready pair low until the ready wire goes low, then time how long the wire stays low after release
  task automatic do_ready(input logic async_src);
    int n;
    @(posedge clk);
    if (async_src) begin
      async_ready_n_n  <= 1'b0;
      arden_n <= 1'b0;
    end else begin
      sync_ready_n_n  <= 1'b0;
      srden_n <= 1'b0;
    end
    wait_sig(1, 1'b0, n);
    @(posedge clk);
    {async_ready_n_n, arden_n, sync_ready_n_n, srden_n} <= 4'hF;
    n = 0;
    while (rdy_w === 1'b0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    `CHK(n >= 16 && n < 100, 1'b1)
  endtask

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic t_reset();
    int n;
    repeat (12) @(negedge clk);
    `CHK({rst_out, rdy_oe, rdy_out, pclk, sys}, 5'h1A)
    `CHK(rdy_w, 1'b0)
    @(posedge clk);
    reset_n <= 1'b1;
    wait_sig(0, 1'b0, n);
    `CHK(rdy_w, 1'b1)
  endtask

  task automatic t_crystal();
    int   s, p;
    logic x1, x2;
    count_edges(96, s, p);
    `CHK(s, 12)
    `CHK(p, 6)
    // Crystal drive pin is the inverted wave, two sync stages late
    @(negedge clk);
    x2 = xtal;
    @(negedge clk);
    x1 = xtal;
    repeat (16) begin
      @(negedge clk);
      `CHK(xout, !x2)
      x2 = x1;
      x1 = xtal;
    end
  endtask

  task automatic t_switch();
    int s, p;
    @(posedge clk);
    sel <= 1'b1;
    repeat (200) @(negedge clk);
    count_edges(96, s, p);
    `CHK(s, 8)
    `CHK(p, 4)
    `CHK(rst_out, 1'b0)
    @(posedge clk);
    sel <= 1'b0;
    repeat (200) @(negedge clk);
    count_edges(96, s, p);
    `CHK(s, 12)
  endtask

  task automatic t_reset_req();
    int n;
    @(posedge clk);
    rrq_n <= 1'b0;
    @(negedge clk);
    wait_sig(0, 1'b1, n);
    `CHK(n <= 20, 1'b1)
    repeat (40) @(negedge clk);
    `CHK(rdy_w, 1'b0)
    @(posedge clk);
    rrq_n <= 1'b1;
    wait_sig(0, 1'b0, n);
    `CHK(n <= 20, 1'b1)
    repeat (40) @(negedge clk);
    `CHK(rdy_w, 1'b1)
  endtask

  task automatic t_sync_ready();
    do_ready(1'b0);
    `CHK(rdy_w, 1'b1)
  endtask

  task automatic t_async_ready();
    do_ready(1'b1);
    `CHK(rdy_w, 1'b1)
  endtask

  task automatic t_no_enable();
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    sync_ready_n_n <= 1'b0;
    async_ready_n_n <= 1'b0;
    repeat (48) begin
      @(negedge clk);
      if (rdy_w !== 1'b1) seen = 1'b1;
    end
    `CHK(seen, 1'b0)
    @(posedge clk);
    sync_ready_n_n <= 1'b1;
    async_ready_n_n <= 1'b1;
  endtask

  // Clock enable low must freeze both generated clocks
  task automatic t_hold();
    logic [1:0] held;
    @(posedge clk);
    ce <= 1'b0;
    @(negedge clk);
    held = {sys, pclk};
    repeat (20) begin
      @(negedge clk);
      `CHK({sys, pclk}, held)
    end
    @(posedge clk);
    ce <= 1'b1;
  endtask

  task automatic t_status();
    logic lowp, lowr;
    int   s, p;
    for (int k = 0; k < 2; k++) begin
      lowp = 1'b0;
      lowr = 1'b0;
      @(posedge clk);
      stlo_n  <= (k == 1);
      sthi_n  <= (k == 0);
      sync_ready_n_n  <= 1'b0;
      srden_n <= 1'b0;
      repeat (32) @(negedge clk);
      repeat (48) begin
        @(negedge clk);
        if (pclk !== 1'b1) lowp = 1'b1;
        if (rdy_w !== 1'b1) lowr = 1'b1;
      end
      `CHK(lowp, 1'b0)
      `CHK(lowr, 1'b0)
      @(posedge clk);
      {stlo_n, sthi_n, sync_ready_n_n, srden_n} <= 4'hF;
      repeat (24) @(negedge clk);
      count_edges(96, s, p);
      `CHK(p, 6)
    end
  endtask

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    t_reset();
    t_crystal();
    t_switch();
    t_reset_req();
    t_sync_ready();
    t_async_ready();
    t_no_enable();
    t_hold();
    t_status();
    t_crystal();
    finish_test();
  end
endmodule

`default_nettype wire
